// [src/ubfc_regs.vh]
// Register map, field positions, reset values and timing for the UART baud and flow block.
// Assumes a flat 5-bit register index driven by the host-side register port.
`ifndef UBFC_REGS_VH
`define UBFC_REGS_VH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define UBFC_A_DIV_LO      5'h00
`define UBFC_A_DIV_HI      5'h01
`define UBFC_A_DIV_FRAC    5'h02
`define UBFC_A_ENH_CTRL    5'h03
`define UBFC_A_RESUME1     5'h04
`define UBFC_A_RESUME2     5'h05
`define UBFC_A_HALT1       5'h06
`define UBFC_A_HALT2       5'h07
`define UBFC_A_INT_EN      5'h08
`define UBFC_A_INT_STAT    5'h09
`define UBFC_A_FIFO_CTRL   5'h0a
`define UBFC_A_LINE_CTRL   5'h0b
`define UBFC_A_MODEM_CTRL  5'h0c
`define UBFC_A_MODEM_STAT  5'h0d
`define UBFC_A_SCRATCH     5'h0e
`define UBFC_A_FLOW_LEVEL  5'h0f
`define UBFC_A_TRIG_LEVEL  5'h10
`define UBFC_A_EXTRA_CTRL  5'h11
`define UBFC_A_GPIO_CTRL   5'h12

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UBFC_RST_DIV_LO     8'h01
`define UBFC_RST_DIV_HI     8'h00
`define UBFC_RST_SCRATCH    8'hff
`define UBFC_RST_FLOWCHAR   8'h00
`define UBFC_RST_LINE_CTRL  8'h1d
`define UBFC_RST_FLOW_LEVEL 8'h0f
`define UBFC_RST_INT_STAT   8'h01
`define UBFC_RST_ZERO       8'h00

// ----------------------------------------------------------------
// Field positions and write masks
// ----------------------------------------------------------------
`define UBFC_ENH_EN_BIT     4
`define UBFC_SPECIAL_BIT    5
`define UBFC_AUTO_RTS_BIT   6
`define UBFC_AUTO_CTS_BIT   7
`define UBFC_MCR_RTS_BIT    1
`define UBFC_IER_SPEC_BIT   5
`define UBFC_ISR_SPEC_BIT   4
`define UBFC_XTRA_TXDIS_BIT 2
`define UBFC_GPIO_SRST_BIT  3
`define UBFC_MASK_IER       8'hf0
`define UBFC_MASK_ISR       8'h30
`define UBFC_MASK_FCR       8'h30
`define UBFC_MASK_MCR       8'he4

// ----------------------------------------------------------------
// Flow-select and sampling encodings
// ----------------------------------------------------------------
`define UBFC_FLOW_NONE      2'b00
`define UBFC_FLOW_ONE       2'b10
`define UBFC_FLOW_TWO       2'b01
`define UBFC_FLOW_BOTH      2'b11
`define UBFC_OVS_16         5'h10
`define UBFC_OVS_8          5'h08
`define UBFC_OVS_4          5'h04
`define UBFC_FRAC_ONE       21'h000010
`define UBFC_RX_TRIG_DEF    7'h08

`endif

// [src/ubfc_char_buf.v]
// Two-entry character buffer with valid/ready on both sides.
// Assumes one clock; outputs come from flip-flops.
`timescale 1ns/10ps
`default_nettype none

module ubfc_char_buf (
  input  wire       i_clk_sys,
  input  wire       i_reset_n,
  input  wire       i_in_valid,
  input  wire [7:0] i_in_data,
  output wire       o_in_ready,
  output reg        o_out_valid,
  output reg  [7:0] o_out_data,
  input  wire       i_out_ready
);

  reg       tail_valid_reg;
  reg [7:0] tail_data_reg;
  wire      push;
  wire      pop;

  // Room exists unless the second slot is occupied
  assign o_in_ready = ~tail_valid_reg;
  assign push       = i_in_valid & ~tail_valid_reg;
  assign pop        = o_out_valid & i_out_ready;

  // ----------------------------------------------------------------
  // Head and tail slots
  // ----------------------------------------------------------------
  // Head shifts from tail on pop so order is kept
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_out_valid    <= 1'b0;
      o_out_data     <= 8'h00;
      tail_valid_reg <= 1'b0;
      tail_data_reg  <= 8'h00;
    end else begin
      if (pop) begin
        if (tail_valid_reg) begin
          o_out_data     <= tail_data_reg;
          tail_valid_reg <= push;
          tail_data_reg  <= i_in_data;
        end else begin
          o_out_valid <= push;
          o_out_data  <= i_in_data;
        end
      end else if (push) begin
        if (o_out_valid) begin
          tail_valid_reg <= 1'b1;
          tail_data_reg  <= i_in_data;
        end else begin
          o_out_valid <= 1'b1;
          o_out_data  <= i_in_data;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [src/ubfc_top.v]
// UART baud generator, enhanced-feature gate and software/hardware flow control.
// Assumes receiver, FIFOs and transmitter sit outside and share i_clk_sys.
`timescale 1ns/10ps
`default_nettype none
`include "ubfc_regs.vh"

module ubfc_top (
  input  wire       i_clk_sys,
  input  wire       i_reset_n,
  input  wire       i_por_n,
  input  wire [4:0] i_reg_addr,
  input  wire       i_reg_wr,
  input  wire       i_reg_rd,
  input  wire [7:0] i_reg_wdata,
  output reg  [7:0] o_reg_rdata,
  input  wire       i_rx_valid,
  input  wire [7:0] i_rx_data,
  input  wire [6:0] i_rx_level,
  input  wire       i_cts_n,
  input  wire       i_dsr_n,
  input  wire       i_ri_n,
  input  wire       i_cd_n,
  output reg        o_rx_store_valid,
  output reg  [7:0] o_rx_store_data,
  output reg        o_xoff_irq,
  output reg        o_special_irq,
  output reg        o_rx_trig_irq,
  output reg        o_rts_n,
  output reg        o_tx_allowed,
  output reg        o_sample_tick,
  output reg        o_bit_tick,
  output wire       o_flow_char_valid,
  output wire [7:0] o_flow_char_data,
  input  wire       i_flow_char_ready
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_FIRST  = 3'b010;
  localparam [2:0] ST_SECOND = 3'b100;

  reg  [7:0]  div_lo_reg, div_hi_reg, scratch_reg;
  reg  [7:0]  resume1_reg, resume2_reg, halt1_reg, halt2_reg;
  reg  [7:0]  frac_reg, enh_reg, ier_reg, isr_reg, fcr_reg, lcr_reg, mcr_reg;
  reg  [7:0]  msr_reg, tcr_reg, tlr_reg, xtra_reg, gpio_ctrl_reg;
  reg         msr_load_reg;
  reg  [3:0]  modem_prev_reg;
  reg         seq_on_reg, seq_off_reg, sw_halted_reg, xoff_sent_reg, auto_hold_reg;
  reg  [2:0]  tx_state_reg;
  reg         send_off_reg;
  reg  [20:0] acc_reg;
  reg  [4:0]  ovs_cnt_reg;
  reg         push_valid;
  reg  [7:0]  push_data;
  reg  [7:0]  rdata_next;
  reg         match_on, match_off;
  wire        push_ready;
  wire        wr_en, soft_rst, enh;
  wire [1:0]  rx_mode, tx_mode;
  wire [3:0]  modem_lvl;
  wire [20:0] div16, acc_sum;
  wire [4:0]  ovs;
  wire [6:0]  halt_lvl, resume_lvl, trig_lvl;
  wire        eq_on1, eq_on2, eq_off1, eq_off2, spec_hit, either_pair;

  assign wr_en     = i_reg_wr;
  assign soft_rst  = gpio_ctrl_reg[`UBFC_GPIO_SRST_BIT];
  assign enh       = enh_reg[`UBFC_ENH_EN_BIT];
  assign rx_mode   = enh_reg[1:0];
  assign tx_mode   = enh_reg[3:2];
  assign modem_lvl = ~{i_cd_n, i_ri_n, i_dsr_n, i_cts_n};

  // ----------------------------------------------------------------
  // Power-up-only registers
  // ----------------------------------------------------------------
  // Power-up reset only
  // Pin reset and soft reset deliberately do not reach these
  always @(posedge i_clk_sys or negedge i_por_n) begin
    if (!i_por_n) begin
      div_lo_reg  <= `UBFC_RST_DIV_LO;
      div_hi_reg  <= `UBFC_RST_DIV_HI;
      scratch_reg <= `UBFC_RST_SCRATCH;
      resume1_reg <= `UBFC_RST_FLOWCHAR;
      resume2_reg <= `UBFC_RST_FLOWCHAR;
      halt1_reg   <= `UBFC_RST_FLOWCHAR;
      halt2_reg   <= `UBFC_RST_FLOWCHAR;
    end else if (wr_en) begin
      case (i_reg_addr)
        `UBFC_A_DIV_LO:  div_lo_reg  <= i_reg_wdata;
        `UBFC_A_DIV_HI:  div_hi_reg  <= i_reg_wdata;
        `UBFC_A_SCRATCH: scratch_reg <= i_reg_wdata;
        `UBFC_A_RESUME1: resume1_reg <= i_reg_wdata;
        `UBFC_A_RESUME2: resume2_reg <= i_reg_wdata;
        `UBFC_A_HALT1:   halt1_reg   <= i_reg_wdata;
        `UBFC_A_HALT2:   halt2_reg   <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Resettable control registers
  // ----------------------------------------------------------------
  // Reset clears enhanced
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frac_reg      <= `UBFC_RST_ZERO;
      enh_reg       <= `UBFC_RST_ZERO;
      ier_reg       <= `UBFC_RST_ZERO;
      isr_reg       <= `UBFC_RST_INT_STAT;
      fcr_reg       <= `UBFC_RST_ZERO;
      lcr_reg       <= `UBFC_RST_LINE_CTRL;
      mcr_reg       <= `UBFC_RST_ZERO;
      tcr_reg       <= `UBFC_RST_FLOW_LEVEL;
      tlr_reg       <= `UBFC_RST_ZERO;
      xtra_reg      <= `UBFC_RST_ZERO;
      gpio_ctrl_reg <= `UBFC_RST_ZERO;
    end else if (soft_rst) begin
      frac_reg      <= `UBFC_RST_ZERO;
      enh_reg       <= `UBFC_RST_ZERO;
      ier_reg       <= `UBFC_RST_ZERO;
      isr_reg       <= `UBFC_RST_INT_STAT;
      fcr_reg       <= `UBFC_RST_ZERO;
      lcr_reg       <= `UBFC_RST_LINE_CTRL;
      mcr_reg       <= `UBFC_RST_ZERO;
      tcr_reg       <= `UBFC_RST_FLOW_LEVEL;
      tlr_reg       <= `UBFC_RST_ZERO;
      xtra_reg      <= `UBFC_RST_ZERO;
      gpio_ctrl_reg <= `UBFC_RST_ZERO;
    end else begin
      if (wr_en) begin
        case (i_reg_addr)
          `UBFC_A_DIV_FRAC:   if (enh) frac_reg <= i_reg_wdata;
          `UBFC_A_ENH_CTRL:   enh_reg <= i_reg_wdata;
          `UBFC_A_INT_EN:     ier_reg <= enh ? i_reg_wdata
                                             : (ier_reg & `UBFC_MASK_IER) | (i_reg_wdata & ~`UBFC_MASK_IER);
          `UBFC_A_INT_STAT:   if (enh) isr_reg <= (isr_reg & ~`UBFC_MASK_ISR) | (i_reg_wdata & `UBFC_MASK_ISR);
          `UBFC_A_FIFO_CTRL:  fcr_reg <= enh ? i_reg_wdata
                                             : (fcr_reg & `UBFC_MASK_FCR) | (i_reg_wdata & ~`UBFC_MASK_FCR);
          `UBFC_A_LINE_CTRL:  lcr_reg <= i_reg_wdata;
          `UBFC_A_MODEM_CTRL: mcr_reg <= enh ? i_reg_wdata
                                             : (mcr_reg & `UBFC_MASK_MCR) | (i_reg_wdata & ~`UBFC_MASK_MCR);
          `UBFC_A_FLOW_LEVEL: if (enh) tcr_reg <= i_reg_wdata;
          `UBFC_A_TRIG_LEVEL: if (enh) tlr_reg <= i_reg_wdata;
          `UBFC_A_EXTRA_CTRL: xtra_reg <= i_reg_wdata;
          `UBFC_A_GPIO_CTRL:  gpio_ctrl_reg <= i_reg_wdata;
          default: ;
        endcase
      end
      // Special flag set
      // Set placed last so a same-cycle write never loses the event
      if (spec_hit) begin
        isr_reg[`UBFC_ISR_SPEC_BIT] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Modem status
  // ----------------------------------------------------------------
  // Load inverted levels
  // Inputs are caught one edge after reset release, never in the reset branch
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      msr_reg        <= 8'h00;
      msr_load_reg   <= 1'b1;
      modem_prev_reg <= 4'h0;
    end else if (soft_rst || msr_load_reg) begin
      msr_reg        <= {modem_lvl, 4'h0};
      msr_load_reg   <= 1'b0;
      modem_prev_reg <= modem_lvl;
    end else begin
      modem_prev_reg <= modem_lvl;
      msr_reg[7:4]   <= modem_lvl;
      // Delta bits: change sets, read clears, set wins
      msr_reg[3:0]   <= ((i_reg_rd && i_reg_addr == `UBFC_A_MODEM_STAT) ? 4'h0 : msr_reg[3:0])
                        | (modem_lvl ^ modem_prev_reg);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  always @* begin
    case (i_reg_addr)
      `UBFC_A_DIV_LO:     rdata_next = div_lo_reg;
      `UBFC_A_DIV_HI:     rdata_next = div_hi_reg;
      `UBFC_A_DIV_FRAC:   rdata_next = enh ? frac_reg : 8'h00;
      `UBFC_A_ENH_CTRL:   rdata_next = enh_reg;
      `UBFC_A_RESUME1:    rdata_next = resume1_reg;
      `UBFC_A_RESUME2:    rdata_next = resume2_reg;
      `UBFC_A_HALT1:      rdata_next = halt1_reg;
      `UBFC_A_HALT2:      rdata_next = halt2_reg;
      `UBFC_A_INT_EN:     rdata_next = ier_reg;
      `UBFC_A_INT_STAT:   rdata_next = isr_reg;
      `UBFC_A_FIFO_CTRL:  rdata_next = fcr_reg;
      `UBFC_A_LINE_CTRL:  rdata_next = lcr_reg;
      `UBFC_A_MODEM_CTRL: rdata_next = mcr_reg;
      `UBFC_A_MODEM_STAT: rdata_next = msr_reg;
      `UBFC_A_SCRATCH:    rdata_next = scratch_reg;
      `UBFC_A_FLOW_LEVEL: rdata_next = tcr_reg;
      `UBFC_A_TRIG_LEVEL: rdata_next = tlr_reg;
      `UBFC_A_EXTRA_CTRL: rdata_next = xtra_reg;
      `UBFC_A_GPIO_CTRL:  rdata_next = gpio_ctrl_reg;
      default:            rdata_next = 8'h00;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Fractional baud generator
  // ----------------------------------------------------------------
  // Divisor in sixteenths
  assign div16   = {1'b0, div_hi_reg, div_lo_reg, frac_reg[3:0]};
  assign acc_sum = acc_reg + `UBFC_FRAC_ONE;
  assign ovs     = frac_reg[5] ? `UBFC_OVS_4 : (frac_reg[4] ? `UBFC_OVS_8 : `UBFC_OVS_16);

  // Bit period chain
  // Integer part zero stops the generator rather than ticking every clock
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_reg       <= 21'h000000;
      ovs_cnt_reg   <= 5'h00;
      o_sample_tick <= 1'b0;
      o_bit_tick    <= 1'b0;
    end else if (div16 < `UBFC_FRAC_ONE) begin
      acc_reg       <= 21'h000000;
      ovs_cnt_reg   <= 5'h00;
      o_sample_tick <= 1'b0;
      o_bit_tick    <= 1'b0;
    end else if (acc_sum >= div16) begin
      acc_reg       <= acc_sum - div16;
      o_sample_tick <= 1'b1;
      o_bit_tick    <= (ovs_cnt_reg >= ovs - 5'h01);
      ovs_cnt_reg   <= (ovs_cnt_reg >= ovs - 5'h01) ? 5'h00 : ovs_cnt_reg + 5'h01;
    end else begin
      acc_reg       <= acc_sum;
      o_sample_tick <= 1'b0;
      o_bit_tick    <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Receive comparison
  // ----------------------------------------------------------------
  assign eq_on1      = (i_rx_data == resume1_reg);
  assign eq_on2      = (i_rx_data == resume2_reg);
  assign eq_off1     = (i_rx_data == halt1_reg);
  assign eq_off2     = (i_rx_data == halt2_reg);
  assign either_pair = (tx_mode == `UBFC_FLOW_ONE) || (tx_mode == `UBFC_FLOW_TWO);
  assign spec_hit    = i_rx_valid & enh_reg[`UBFC_SPECIAL_BIT] & eq_off2;

  always @* begin
    case (rx_mode)
      `UBFC_FLOW_ONE: begin
        match_on  = eq_on1;
        match_off = eq_off1;
      end
      `UBFC_FLOW_TWO: begin
        match_on  = eq_on2;
        match_off = eq_off2;
      end
      `UBFC_FLOW_BOTH: begin
        match_on  = either_pair ? (eq_on1 | eq_on2) : (seq_on_reg & eq_on2);
        match_off = either_pair ? (eq_off1 | eq_off2) : (seq_off_reg & eq_off2);
      end
      default: begin
        match_on  = 1'b0;
        match_off = 1'b0;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      seq_on_reg       <= 1'b0;
      seq_off_reg      <= 1'b0;
      sw_halted_reg    <= 1'b0;
      o_rx_store_valid <= 1'b0;
      o_rx_store_data  <= 8'h00;
      o_xoff_irq       <= 1'b0;
      o_special_irq    <= 1'b0;
    end else begin
      o_rx_store_valid <= i_rx_valid & ~(spec_hit & (rx_mode == `UBFC_FLOW_TWO));
      o_xoff_irq       <= i_rx_valid & match_off;
      o_special_irq    <= isr_reg[`UBFC_ISR_SPEC_BIT] & ier_reg[`UBFC_IER_SPEC_BIT];
      if (i_rx_valid) begin
        o_rx_store_data <= i_rx_data;
        seq_on_reg      <= eq_on1;
        seq_off_reg     <= eq_off1;
        if (match_off) begin
          sw_halted_reg <= 1'b1;
        end else if (match_on) begin
          sw_halted_reg <= 1'b0;
        end
      end
      if (rx_mode == `UBFC_FLOW_NONE) begin
        sw_halted_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Levels and hardware flow control
  // ----------------------------------------------------------------
  // Halt level
  assign halt_lvl   = {1'b0, tcr_reg[3:0], 2'b00};
  assign resume_lvl = {1'b0, tcr_reg[7:4], 2'b00};
  assign trig_lvl   = (tlr_reg[7:4] != 4'h0) ? {1'b0, tlr_reg[7:4], 2'b00} : `UBFC_RX_TRIG_DEF;

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      auto_hold_reg <= 1'b0;
      o_rts_n       <= 1'b1;
      o_tx_allowed  <= 1'b0;
      o_rx_trig_irq <= 1'b0;
    end else begin
      if (i_rx_level >= halt_lvl) begin
        auto_hold_reg <= 1'b1;
      end else if (i_rx_level < resume_lvl) begin
        auto_hold_reg <= 1'b0;
      end
      o_rts_n       <= ~mcr_reg[`UBFC_MCR_RTS_BIT]
                       | (enh_reg[`UBFC_AUTO_RTS_BIT] & auto_hold_reg);
      o_rx_trig_irq <= (i_rx_level >= trig_lvl);
      o_tx_allowed  <= ~(enh_reg[`UBFC_AUTO_CTS_BIT] & i_cts_n) & ~sw_halted_reg
                       & ~xtra_reg[`UBFC_XTRA_TXDIS_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Transmit software flow characters
  // ----------------------------------------------------------------
  // Transmit character select
  always @* begin
    push_valid = 1'b0;
    push_data  = 8'h00;
    case (tx_state_reg)
      ST_FIRST: begin
        push_valid = 1'b1;
        push_data  = (tx_mode == `UBFC_FLOW_TWO) ? (send_off_reg ? halt2_reg : resume2_reg)
                                                  : (send_off_reg ? halt1_reg : resume1_reg);
      end
      ST_SECOND: begin
        push_valid = 1'b1;
        push_data  = send_off_reg ? halt2_reg : resume2_reg;
      end
      ST_IDLE: ;
      default: ;
    endcase
  end

  // One- or two-character send
  // Buffer back-pressure holds the state, so no character is dropped
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_state_reg  <= ST_IDLE;
      send_off_reg  <= 1'b0;
      xoff_sent_reg <= 1'b0;
    end else begin
      case (tx_state_reg)
        ST_IDLE: begin
          if (tx_mode == `UBFC_FLOW_NONE) begin
            xoff_sent_reg <= 1'b0;
          end else if (!xoff_sent_reg && i_rx_level >= halt_lvl) begin
            send_off_reg  <= 1'b1;
            xoff_sent_reg <= 1'b1;
            tx_state_reg  <= ST_FIRST;
          end else if (xoff_sent_reg && i_rx_level <= resume_lvl) begin
            send_off_reg  <= 1'b0;
            xoff_sent_reg <= 1'b0;
            tx_state_reg  <= ST_FIRST;
          end
        end
        ST_FIRST: begin
          if (push_ready) begin
            tx_state_reg <= (tx_mode == `UBFC_FLOW_BOTH) ? ST_SECOND : ST_IDLE;
          end
        end
        ST_SECOND: begin
          if (push_ready) begin
            tx_state_reg <= ST_IDLE;
          end
        end
        default: tx_state_reg <= ST_IDLE;
      endcase
    end
  end

  ubfc_char_buf u_char_buf (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (push_valid),
    .i_in_data   (push_data),
    .o_in_ready  (push_ready),
    .o_out_valid (o_flow_char_valid),
    .o_out_data  (o_flow_char_data),
    .i_out_ready (i_flow_char_ready)
  );

endmodule

`default_nettype wire

// [sim/ubfc_props_properties.sv]
// Port checker for ubfc_top: ticks, receive store, flow char hand-off.
// Assumes one clock domain; bound below onto every ubfc_top.
`timescale 1ns/10ps
`default_nettype none

module ubfc_props (
  input wire logic       i_clk_sys,
  input wire logic       i_reset_n,
  input wire logic       i_reg_wr,
  input wire logic       i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic       o_rx_store_valid,
  input wire logic [7:0] o_rx_store_data,
  input wire logic       o_xoff_irq,
  input wire logic       o_special_irq,
  input wire logic       o_sample_tick,
  input wire logic       o_bit_tick,
  input wire logic       o_flow_char_valid,
  input wire logic [7:0] o_flow_char_data,
  input wire logic       i_flow_char_ready
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // Stalled word must wait in the buffer
  sequence s_stalled;
    o_flow_char_valid && !i_flow_char_ready;
  endsequence
  a_bit_in_sample: assert property (o_bit_tick |-> o_sample_tick)
    else $error("bit tick off sample grid");
  a_bit_spacing: assert property (o_bit_tick |=> !o_bit_tick [*3])
    else $error("bit ticks closer than four samples");
  a_store_data: assert property (o_rx_store_valid |-> $past(i_rx_valid) && o_rx_store_data == $past(i_rx_data))
    else $error("stored char not the received one");
  a_xoff_cause: assert property (o_xoff_irq |-> $past(i_rx_valid))
    else $error("halt pulse without received char");
  a_flow_hold: assert property (s_stalled |=> o_flow_char_valid && $stable(o_flow_char_data))
    else $error("flow char lost under stall");
  a_flow_taken: assert property ($fell(o_flow_char_valid) |-> $past(i_flow_char_ready))
    else $error("flow char withdrawn unaccepted");
  // A clearing write reaches the irq two edges later, soft reset one more
  a_special_hold: assert property (o_special_irq && !i_reg_wr && !$past(i_reg_wr) && !$past(i_reg_wr, 2)
    |=> o_special_irq)
    else $error("special irq dropped without write");
  a_special_lag: assert property ($rose(o_special_irq) |-> $past(i_rx_valid, 2) || $past(i_reg_wr)
    || $past(i_reg_wr, 2))
    else $error("special irq without cause");
endmodule

bind ubfc_top ubfc_props u_props (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr),
  .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .o_rx_store_valid(o_rx_store_valid),
  .o_rx_store_data(o_rx_store_data), .o_xoff_irq(o_xoff_irq), .o_special_irq(o_special_irq),
  .o_sample_tick(o_sample_tick), .o_bit_tick(o_bit_tick), .o_flow_char_valid(o_flow_char_valid),
  .o_flow_char_data(o_flow_char_data), .i_flow_char_ready(i_flow_char_ready));
`default_nettype wire

// [sim/ubfc_remote_peer.sv]
// Remote serial equipment taking flow chars from the transmitter side.
// Assumes the same clock; accepts one word in four cycles.
`timescale 1ns/10ps
`default_nettype none

module ubfc_remote_peer (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset_n,
  input  wire logic       i_char_valid,
  input  wire logic [7:0] i_char_data,
  output logic            o_char_ready,
  output logic [7:0]      o_last_char,
  output logic [7:0]      o_char_count
);
  logic [1:0] slot_reg;
  // Slow taker, so the buffer really has to hold words
  assign o_char_ready = (slot_reg == 2'b11);
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      slot_reg <= 2'b00;
      o_last_char <= 8'h00;
      o_char_count <= 8'h00;
    end else begin
      slot_reg <= slot_reg + 2'b01;
      if (i_char_valid && o_char_ready) begin
        o_last_char <= i_char_data;
        o_char_count <= o_char_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/ubfc_tb_top.sv]
// Bench for ubfc_top: registers, baud, receive match, flow control.
// Assumes the remote peer model and the bound checker.
`timescale 1ns/10ps
`default_nettype none

module ubfc_tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, wr = 1'b0, rd = 1'b0, rxv = 1'b0, cts_n = 1'b0;
  logic [4:0]  addr = 5'h00;
  logic [6:0]  lvl = 7'h00;
  logic [7:0]  wd = 8'h00, rxd = 8'h00, rdat, st_d, fc_d, last_c, fc_n, h2;
  logic        st_v, xoff, spec, trig, rts_n, tx_ok, stk, btk, fc_v, fc_r;
  integer      err_count = 0, total_checks = 0, seed = 54, i, sc = 0, bc = 0, xn = 0;
  logic [7:0]  exp_q[$];
  logic [15:0] rtab [0:9] = '{16'h0001, 16'h0100, 16'h0200, 16'h0300, 16'h0eff, 16'h0b1d, 16'h0901,
                              16'h0f0f, 16'h0d50, 16'h1f00};
  logic [31:0] btab [0:3] = '{32'h00a0_5005, 32'h10a0_500a, 32'h28c8_5014, 32'h30a0_5014};
  always #10 clk = ~clk;
  ubfc_top uut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_por_n(por_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat), .i_rx_valid(rxv), .i_rx_data(rxd),
    .i_rx_level(lvl), .i_cts_n(cts_n), .i_dsr_n(1'b1), .i_ri_n(1'b0), .i_cd_n(1'b1),
    .o_rx_store_valid(st_v), .o_rx_store_data(st_d), .o_xoff_irq(xoff), .o_special_irq(spec),
    .o_rx_trig_irq(trig), .o_rts_n(rts_n), .o_tx_allowed(tx_ok), .o_sample_tick(stk), .o_bit_tick(btk),
    .o_flow_char_valid(fc_v), .o_flow_char_data(fc_d), .i_flow_char_ready(fc_r));
  ubfc_remote_peer peer (.i_clk_sys(clk), .i_reset_n(rst_n), .i_char_valid(fc_v), .i_char_data(fc_d),
    .o_char_ready(fc_r), .o_last_char(last_c), .o_char_count(fc_n));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Every drive lands 1 ns after a rising edge
  task cyc(input integer k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wrt(input logic [4:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  // Data is compared a cycle late; it holds until the next read
  task rdc(input logic [4:0] a, input logic [7:0] e);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    chk(rdat, e);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Tick counters and the receive store model
  always @(posedge clk) begin
    if (stk === 1'b1) sc = sc + 1;
    if (btk === 1'b1) bc = bc + 1;
    if (xoff === 1'b1) xn = xn + 1;
    if (st_v === 1'b1) chk(st_d, exp_q.size() ? exp_q.pop_front() : 8'hxx);
  end
  initial begin
    #200000;
    err_count++;
    final_report;
  end
  initial begin
    cyc(3);
    rst_n = 1'b1;
    por_n = 1'b1;
    for (i = 0; i < 10; i++) rdc(rtab[i][12:8], rtab[i][7:0]);
    wrt(5'h02, 8'h15);
    wrt(5'h03, 8'h10);
    wrt(5'h02, 8'h15);
    wrt(5'h03, 8'h00);
    wrt(5'h02, 8'h33);
    rdc(5'h02, 8'h00);
    wrt(5'h03, 8'h10);
    rdc(5'h02, 8'h15);
    h2 = 8'h80 | 8'($random(seed));
    wrt(5'h00, h2);
    wrt(5'h0e, h2);
    rst_n = 1'b0;
    cyc(2);
    rst_n = 1'b1;
    rdc(5'h00, h2);
    rdc(5'h0e, h2);
    // Enable first, so a zero read means the fraction was cleared
    wrt(5'h03, 8'h10);
    rdc(5'h02, 8'h00);
    $display("done: registers");
    wrt(5'h00, 8'h02);
    for (i = 0; i < 4; i++) begin
      wrt(5'h02, btab[i][31:24]);
      cyc(40);
      sc = 0;
      bc = 0;
      cyc(btab[i][23:16]);
      chk(8'(sc), btab[i][15:8]);
      chk(8'(bc), btab[i][7:0]);
    end
    wrt(5'h03, 8'h90);
    cts_n = 1'b1;
    cyc(4);
    chk({7'h00, tx_ok}, 8'h00);
    cts_n = 1'b0;
    cyc(4);
    chk({7'h00, tx_ok}, 8'h01);
    wrt(5'h11, 8'h04);
    chk({7'h00, tx_ok}, 8'h00);
    wrt(5'h11, 8'h00);
    $display("done: baud and cts");
    // Clear flow selection before each new one
    wrt(5'h03, 8'h10);
    wrt(5'h07, h2);
    wrt(5'h08, 8'h20);
    wrt(5'h03, 8'h31);
    for (i = 0; i < 6; i++) begin
      rxd = (i == 3) ? h2 : {2'b01, 6'($random(seed))};
      if (i != 3) exp_q.push_back(rxd);
      rxv = 1'b1;
      cyc(1);
    end
    rxv = 1'b0;
    cyc(3);
    chk(8'(xn), 8'h01);
    chk({7'h00, spec}, 8'h01);
    wrt(5'h03, 8'h10);
    wrt(5'h03, 8'h32);
    wrt(5'h09, 8'h00);
    cyc(3);
    chk({7'h00, spec}, 8'h00);
    rxd = h2;
    exp_q.push_back(h2);
    rxv = 1'b1;
    cyc(1);
    rxv = 1'b0;
    cyc(3);
    chk({7'h00, spec}, 8'h01);
    chk(8'(exp_q.size()), 8'h00);
    wrt(5'h0f, 8'h12);
    wrt(5'h06, 8'hc1);
    wrt(5'h04, 8'hc2);
    wrt(5'h0c, 8'h02);
    chk({7'h00, rts_n}, 8'h00);
    wrt(5'h03, 8'h10);
    wrt(5'h03, 8'h58);
    lvl = 7'd8;
    cyc(12);
    chk({6'h00, trig, rts_n}, 8'h03);
    chk(last_c, 8'hc1);
    lvl = 7'd4;
    cyc(12);
    chk({fc_n[6:0], rts_n}, 8'h05);
    chk(last_c, 8'hc2);
    lvl = 7'd3;
    cyc(4);
    chk({7'h00, rts_n}, 8'h00);
    // Dual mode: halt one then halt two back to back
    wrt(5'h03, 8'h10);
    wrt(5'h03, 8'h5c);
    lvl = 7'd8;
    cyc(16);
    chk(fc_n, 8'h04);
    chk(last_c, h2);
    $display("done: receive and flow");
    final_report;
  end
endmodule
`default_nettype wire
